// ---- rtl/kbd_emu_consts.svh ----
// Register offsets, field positions, reset values and port numbers of keyboard emulation.
`ifndef KBD_EMU_CONSTS_SVH
`define KBD_EMU_CONSTS_SVH

// ****************************************************************
// Register byte offsets in the operational register space
// ****************************************************************
`define EMU_CONTROL_OFS 12'h100
`define EMU_INPUT_OFS 12'h104
`define EMU_OUTPUT_OFS 12'h108
`define EMU_STATUS_OFS 12'h10c

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTL_WIDTH 9
`define CTL_RESET 9'h010
`define CTL_INTERCEPT 0
`define CTL_SOFT_IRQ 1
`define CTL_CHAR_WAIT 2
`define CTL_KBD_ALLOW 3
`define CTL_EXT_ALLOW 4
`define CTL_A20_SEEN 5
`define CTL_KBD_ROSE 6
`define CTL_MOUSE_ROSE 7
`define CTL_A20_LEVEL 8

// ****************************************************************
// Status register fields
// ****************************************************************
`define ST_RESET 8'h00
`define ST_REPLY_READY 0
`define ST_CAPT_READY 1
`define ST_BOOT_FLAG 2
`define ST_WAS_CMD 3
`define ST_NOT_INHIBIT 4
`define ST_REPLY_MOUSE 5
`define ST_TIMEOUT 6
`define ST_PARITY 7

// ****************************************************************
// Legacy I/O ports and the gate-A20 command
// ****************************************************************
`define PORT_DATA 16'h0060
`define PORT_CMD 16'h0064
`define A20_CMD 8'hd1
`define A20_DATA_BIT 1

`endif

// ---- rtl/kbd_emu_pkg.sv ----
// Types shared by the keyboard emulation design.
package kbd_emu_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [31:0] word_t;
  typedef logic [11:0] mem_addr_t;
  typedef logic [15:0] io_addr_t;

  // Which emulation register a memory access selects.
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CONTROL = 3'b001,
    SEL_INPUT = 3'b010,
    SEL_OUTPUT = 3'b011,
    SEL_STATUS = 3'b100
  } reg_sel_t;

endpackage : kbd_emu_pkg

// ---- rtl/pin_edge_sync.sv ----
// Three-stage pin synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/100ps
module pin_edge_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  // ****************************************************************
  // One synchroniser per line
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_line
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic rse;
      logic next_level;
      logic next_rise;

      // Each line keeps its own flops, so no output bit has more than one writer.
      assign level[i] = lvl;
      assign rise[i] = rse;

      // The level only moves once the second and third stages agree.
      always_comb begin
        next_level = lvl;
        next_rise = 1'b0;
        if (s2 == s3) begin
          next_level = s3;
          next_rise = s3 & ~lvl;
        end
      end

      // The first stage is read only by the second, to keep metastability contained.
      always_ff @(posedge mclk) begin
        if (reset) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          lvl <= 1'b0;
          rse <= 1'b0;
        end else begin
          s1 <= pin_in[i];
          s2 <= s1;
          s3 <= s2;
          lvl <= next_level;
          rse <= next_rise;
        end
      end
    end
  endgenerate

endmodule : pin_edge_sync

// ---- rtl/usb_legacy_keyboard_emulation.sv ----
// Legacy keyboard port emulation: port 60h/64h intercept, registers and interrupts.
`timescale 1ns/100ps
`include "kbd_emu_consts.svh"

module usb_legacy_keyboard_emulation (
  input wire logic mclk,
  input wire logic reset,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire kbd_emu_pkg::io_addr_t io_addr,
  input wire kbd_emu_pkg::byte_t io_wdata,
  output kbd_emu_pkg::byte_t io_rdata,
  output logic io_claim,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire kbd_emu_pkg::mem_addr_t mem_addr,
  input wire kbd_emu_pkg::word_t mem_wdata,
  output kbd_emu_pkg::word_t mem_rdata,
  output logic mem_ack,
  input wire logic kbc_irq1,
  input wire logic kbc_irq12,
  output logic irq1,
  output logic irq12,
  output logic emu_irq
);
  import kbd_emu_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [`CTL_WIDTH-1:0] control;
  logic [`CTL_WIDTH-1:0] next_control;
  byte_t status;
  byte_t next_status;
  byte_t input_byte;
  byte_t next_input_byte;
  byte_t output_byte;
  byte_t next_output_byte;
  byte_t next_io_rdata;
  logic next_io_claim;
  word_t next_mem_rdata;
  logic next_mem_ack;
  logic next_irq1;
  logic next_irq12;
  logic next_emu_irq;
  logic [1:0] kbc_level;
  logic [1:0] kbc_rise;

  // Register selection from a byte address; used by both read and write paths.
  function automatic reg_sel_t reg_sel(input mem_addr_t addr);
    case (addr)
      `EMU_CONTROL_OFS: reg_sel = SEL_CONTROL;
      `EMU_INPUT_OFS: reg_sel = SEL_INPUT;
      `EMU_OUTPUT_OFS: reg_sel = SEL_OUTPUT;
      `EMU_STATUS_OFS: reg_sel = SEL_STATUS;
      default: reg_sel = SEL_NONE;
    endcase
  endfunction : reg_sel

  // ****************************************************************
  // Keyboard controller interrupt lines
  // ****************************************************************
  // The lines come from another chip, so they are synchronised first.
  pin_edge_sync #(
    .WIDTH(2)
  ) u_kbc_sync (
    .mclk(mclk),
    .reset(reset),
    .pin_in({kbc_irq12, kbc_irq1}),
    .level(kbc_level),
    .rise(kbc_rise)
  );

  // ****************************************************************
  // Port decode and interrupt conditions
  // ****************************************************************
  logic intercept_on;
  logic data_wr;
  logic cmd_wr;
  logic data_rd;
  logic cmd_rd;
  logic a20_cmd;
  logic a20_data;
  logic cond_char;
  logic cond_input;
  logic cond_ext;
  logic soft_assist_irq_flag;

  // Port cycles only count while interception is on.
  assign intercept_on = control[`CTL_INTERCEPT];
  assign data_wr = intercept_on & io_wr & (io_addr == `PORT_DATA);
  assign cmd_wr = intercept_on & io_wr & (io_addr == `PORT_CMD);
  assign data_rd = intercept_on & io_rd & (io_addr == `PORT_DATA);
  assign cmd_rd = intercept_on & io_rd & (io_addr == `PORT_CMD);
  assign a20_cmd = cmd_wr & (io_wdata == `A20_CMD);
  // A data byte that repeats the current A20 level is taken silently; the A20 sequence flag stays set.
  assign a20_data = data_wr & control[`CTL_A20_SEEN]
    & (io_wdata[`A20_DATA_BIT] == control[`CTL_A20_LEVEL]);

  // The three emulation conditions, decoded straight from present state.
  assign cond_char = control[`CTL_CHAR_WAIT] & ~status[`ST_REPLY_READY];
  assign cond_input = status[`ST_CAPT_READY] & intercept_on;
  assign cond_ext = control[`CTL_EXT_ALLOW] & (|kbc_level);
  assign soft_assist_irq_flag = cond_char | cond_input | cond_ext;

  // ****************************************************************
  // Register next values
  // ****************************************************************
  // Memory writes are applied first; port and pin events override them so none is lost.
  always_comb begin
    next_control = control;
    next_status = status;
    next_input_byte = input_byte;
    next_output_byte = output_byte;
    if (mem_wr) begin
      case (reg_sel(mem_addr))
        SEL_CONTROL: begin
          next_control[`CTL_INTERCEPT] = mem_wdata[`CTL_INTERCEPT];
          next_control[`CTL_CHAR_WAIT] = mem_wdata[`CTL_CHAR_WAIT];
          next_control[`CTL_KBD_ALLOW] = mem_wdata[`CTL_KBD_ALLOW];
          next_control[`CTL_EXT_ALLOW] = mem_wdata[`CTL_EXT_ALLOW];
          next_control[`CTL_A20_LEVEL] = mem_wdata[`CTL_A20_LEVEL];
          // Write one clears an edge flag, write zero leaves it.
          if (mem_wdata[`CTL_KBD_ROSE]) begin
            next_control[`CTL_KBD_ROSE] = 1'b0;
          end
          if (mem_wdata[`CTL_MOUSE_ROSE]) begin
            next_control[`CTL_MOUSE_ROSE] = 1'b0;
          end
        end
        SEL_INPUT: next_input_byte = mem_wdata[7:0];
        SEL_OUTPUT: next_output_byte = mem_wdata[7:0];
        SEL_STATUS: next_status = mem_wdata[7:0];
        default: next_control = control;
      endcase
    end
    // Port writes: capture, command/data bit, A20 tracking.
    if (data_wr | cmd_wr) begin
      next_input_byte = io_wdata;
      if (!(a20_cmd | a20_data)) begin
        next_status[`ST_CAPT_READY] = 1'b1;
      end
    end
    if (data_wr) begin
      next_status[`ST_WAS_CMD] = 1'b0;
    end
    if (cmd_wr) begin
      next_status[`ST_WAS_CMD] = 1'b1;
      next_control[`CTL_A20_SEEN] = a20_cmd;
    end
    if (data_rd) begin
      next_status[`ST_REPLY_READY] = 1'b0;
    end
    // A new edge wins over a clear in the same cycle.
    if (kbc_rise[0]) begin
      next_control[`CTL_KBD_ROSE] = 1'b1;
    end
    if (kbc_rise[1]) begin
      next_control[`CTL_MOUSE_ROSE] = 1'b1;
    end
    next_control[`CTL_SOFT_IRQ] = 1'b0;
  end

  // ****************************************************************
  // Answers and interrupt outputs
  // ****************************************************************
  // Every answer is registered, so it appears one cycle after the request.
  always_comb begin
    next_io_rdata = io_rdata;
    if (data_rd) begin
      next_io_rdata = output_byte;
    end else if (cmd_rd) begin
      next_io_rdata = status;
    end
    next_io_claim = data_rd | cmd_rd | data_wr | cmd_wr;
    next_mem_ack = mem_rd | mem_wr;
    next_mem_rdata = 32'h0000_0000;
    if (mem_rd) begin
      case (reg_sel(mem_addr))
        SEL_CONTROL: begin
          next_mem_rdata = {23'h000000, control};
          next_mem_rdata[`CTL_SOFT_IRQ] = soft_assist_irq_flag;
        end
        SEL_INPUT: next_mem_rdata = {24'h000000, input_byte};
        SEL_OUTPUT: next_mem_rdata = {24'h000000, output_byte};
        SEL_STATUS: next_mem_rdata = {24'h000000, status};
        default: next_mem_rdata = 32'h0000_0000;
      endcase
    end
    next_irq1 = intercept_on & control[`CTL_KBD_ALLOW] & status[`ST_REPLY_READY]
      & ~status[`ST_REPLY_MOUSE];
    next_irq12 = intercept_on & control[`CTL_KBD_ALLOW] & status[`ST_REPLY_READY]
      & status[`ST_REPLY_MOUSE];
    next_emu_irq = soft_assist_irq_flag;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      control <= `CTL_RESET;
      status <= `ST_RESET;
      input_byte <= 8'h00;
      output_byte <= 8'h00;
      io_rdata <= 8'h00;
      io_claim <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      mem_ack <= 1'b0;
      irq1 <= 1'b0;
      irq12 <= 1'b0;
      emu_irq <= 1'b0;
    end else begin
      control <= next_control;
      status <= next_status;
      input_byte <= next_input_byte;
      output_byte <= next_output_byte;
      io_rdata <= next_io_rdata;
      io_claim <= next_io_claim;
      mem_rdata <= next_mem_rdata;
      mem_ack <= next_mem_ack;
      irq1 <= next_irq1;
      irq12 <= next_irq12;
      emu_irq <= next_emu_irq;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  reply_read_a: assert property (data_rd |=> !status[`ST_REPLY_READY]
    && io_rdata == $past(output_byte))
    else $error("Port 60h read did not return reply or clear ready.");

  status_read_a: assert property (cmd_rd |=> io_rdata == $past(status))
    else $error("Port 64h read did not return status.");

  byte_capture_a: assert property ((data_wr || cmd_wr) |=> input_byte == $past(io_wdata))
    else $error("Port write byte was not captured.");

  cmd_bit_a: assert property ((data_wr || cmd_wr)
    |=> status[`ST_WAS_CMD] == $past(cmd_wr))
    else $error("Command/data bit wrong after port write.");

  a20_flag_a: assert property (cmd_wr |=> control[`CTL_A20_SEEN]
    == ($past(io_wdata) == `A20_CMD))
    else $error("A20 sequence flag wrong after port 64h write.");

  input_full_a: assert property ((data_wr || cmd_wr) && !a20_cmd && !a20_data
    |=> status[`ST_CAPT_READY])
    else $error("Captured ready not set by port write.");

  irq_route_a: assert property (intercept_on && control[`CTL_KBD_ALLOW]
    && status[`ST_REPLY_READY] |=> irq1 != irq12 && irq12 == $past(status[`ST_REPLY_MOUSE]))
    else $error("Keyboard interrupt routed to the wrong line.");

  char_cond_a: assert property (control[`CTL_CHAR_WAIT] && !status[`ST_REPLY_READY]
    |=> emu_irq)
    else $error("Waiting character did not raise emulation interrupt.");

  ext_irq_a: assert property (control[`CTL_EXT_ALLOW] && kbc_level != 2'b00 |=> emu_irq)
    else $error("Controller interrupt did not raise emulation interrupt.");

  emu_level_a: assert property (emu_irq == $past(soft_assist_irq_flag))
    else $error("Emulation interrupt does not follow its conditions.");

  // Software may legally clear the flag one cycle after it is set, so that write is excused.
  rose_flag_a: assert property (kbc_rise[0] |=> control[`CTL_KBD_ROSE] ##1
    (control[`CTL_KBD_ROSE] || $past(mem_wr && mem_wdata[`CTL_KBD_ROSE]
    && reg_sel(mem_addr) == SEL_CONTROL)))
    else $error("Keyboard edge flag not held after rising edge.");

  mem_quiet_a: assert property (mem_rd && !mem_wr && !io_rd && !io_wr
    |=> status == $past(status))
    else $error("Memory read changed status.");

  ctl_upper_a: assert property (mem_rd && reg_sel(mem_addr) == SEL_CONTROL
    |=> mem_rdata[31:`CTL_WIDTH] == 23'h000000)
    else $error("Reserved control bits read non-zero.");

  ctl_reset_a: assert property ($past(reset) |-> control == `CTL_RESET)
    else $error("Control register reset value wrong.");

endmodule : usb_legacy_keyboard_emulation

// ---- verif/kbc_model.sv ----
// Keyboard controller model that drives its two interrupt request pins.
`timescale 1ns/100ps
module kbc_model (
  input wire logic mclk,
  output logic kbc_irq1,
  output logic kbc_irq12
);
  // Both pins idle low; the controller only ever drives them as plain levels.
  initial begin
    kbc_irq1 = 1'b0;
    kbc_irq12 = 1'b0;
  end

  // Pins change just after an edge, with no phase relation the block may count on.
  task automatic set_line(input int idx, input logic val);
    @(posedge mclk);
    if (idx == 0) begin
      kbc_irq1 <= val;
    end else begin
      kbc_irq12 <= val;
    end
  endtask : set_line
endmodule : kbc_model

// ---- verif/usb_legacy_keyboard_emulation_tb.sv ----
// Self-checking testbench of the legacy keyboard emulation block.
`timescale 1ns/100ps
`include "kbd_emu_consts.svh"
module usb_legacy_keyboard_emulation_tb;
  import kbd_emu_pkg::*;
  typedef struct {mem_addr_t a; word_t w; word_t e;} row_t;
  logic mclk, reset, io_rd, io_wr, io_claim, mem_rd, mem_wr, mem_ack;
  logic kbc_irq1, kbc_irq12, irq1, irq12, emu_irq;
  io_addr_t io_addr;
  byte_t io_wdata, io_rdata, bd;
  mem_addr_t mem_addr;
  word_t mem_wdata, mem_rdata, rd;
  int mismatches, checked;
  // Plain store and read-back cases; the unmapped row must read zero.
  row_t rows[7] = '{'{12'h104, 32'hffffff5a, 32'h5a}, '{12'h108, 32'h3c, 32'h3c},
    '{12'h10c, 32'hd4, 32'hd4}, '{12'h110, 32'hff, 32'h0}, '{12'h100, 32'h110, 32'h110},
    '{12'h100, 32'hfffffe10, 32'h10}, '{12'h10c, 32'h0, 32'h0}};

  usb_legacy_keyboard_emulation u_usb_legacy_keyboard_emulation (.mclk(mclk), .reset(reset),
    .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_claim(io_claim), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .kbc_irq1(kbc_irq1),
    .kbc_irq12(kbc_irq12), .irq1(irq1), .irq12(irq12), .emu_irq(emu_irq));
  kbc_model u_kbc_model (.mclk(mclk), .kbc_irq1(kbc_irq1), .kbc_irq12(kbc_irq12));

  // ****************************************************************
  // Compare, bus and closing tasks
  // ****************************************************************
  task automatic chk_w(input word_t got, input word_t exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_b(input byte_t got, input byte_t exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : chk_b
  task automatic chk_f(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chk_f
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // Interrupt outputs lag their conditions by one cycle, so two edges are allowed.
  task automatic chk_irq(input logic e1, input logic e12, input logic ee);
    cyc(2);
    #1;
    chk_f(irq1, e1);
    chk_f(irq12, e12);
    chk_f(emu_irq, ee);
  endtask : chk_irq
  task automatic mem_wt(input mem_addr_t a, input word_t d);
    @(posedge mclk);
    mem_wr <= 1'b1;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge mclk);
    mem_wr <= 1'b0;
    #1 chk_f(mem_ack, 1'b1);
  endtask : mem_wt
  task automatic mem_rt(input mem_addr_t a, output word_t d);
    @(posedge mclk);
    mem_rd <= 1'b1;
    mem_addr <= a;
    @(posedge mclk);
    mem_rd <= 1'b0;
    #1 chk_f(mem_ack, 1'b1);
    d = mem_rdata;
  endtask : mem_rt
  task automatic io_wt(input io_addr_t p, input byte_t d, input logic claim);
    @(posedge mclk);
    io_wr <= 1'b1;
    io_addr <= p;
    io_wdata <= d;
    @(posedge mclk);
    io_wr <= 1'b0;
    #1 chk_f(io_claim, claim);
  endtask : io_wt
  task automatic io_rt(input io_addr_t p, output byte_t d);
    @(posedge mclk);
    io_rd <= 1'b1;
    io_addr <= p;
    @(posedge mclk);
    io_rd <= 1'b0;
    #1 chk_f(io_claim, 1'b1);
    d = io_rdata;
  endtask : io_rt
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // The whole sequence needs well under a thousand cycles; this cuts a hang short.
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {reset, io_rd, io_wr, mem_rd, mem_wr} = 5'b10000;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    mem_addr = 12'h000;
    mem_wdata = 32'h0;
    mismatches = 0;
    checked = 0;
    cyc(20);
    reset <= 1'b0;
    mem_rt(`EMU_CONTROL_OFS, rd);
    chk_w(rd, 32'h10);
    mem_rt(`EMU_STATUS_OFS, rd);
    chk_w(rd, 32'h0);
    chk_irq(1'b0, 1'b0, 1'b0);
    $display("test reset done");
    foreach (rows[i]) begin
      mem_wt(rows[i].a, rows[i].w);
      mem_rt(rows[i].a, rd);
      chk_w(rd, rows[i].e);
    end
    $display("test register rows done");
    // Controller pins raise the emulation interrupt even with intercept off.
    for (int i = 0; i < 2; i++) begin
      u_kbc_model.set_line(i, 1'b1);
      cyc(8);
      #1 chk_f(emu_irq, 1'b1);
      mem_rt(`EMU_CONTROL_OFS, rd);
      chk_w(rd, (i == 0) ? 32'h52 : 32'h92);
      u_kbc_model.set_line(i, 1'b0);
      cyc(8);
      mem_wt(`EMU_CONTROL_OFS, 32'h10);
      mem_rt(`EMU_CONTROL_OFS, rd);
      chk_w(rd, (i == 0) ? 32'h50 : 32'h90);
      mem_wt(`EMU_CONTROL_OFS, (i == 0) ? 32'h50 : 32'h90);
      mem_rt(`EMU_CONTROL_OFS, rd);
      chk_w(rd, 32'h10);
    end
    $display("test controller pins done");
    mem_wt(`EMU_CONTROL_OFS, 32'h11);
    io_wt(`PORT_DATA, 8'h42, 1'b1);
    mem_rt(`EMU_INPUT_OFS, rd);
    chk_w(rd, 32'h42);
    mem_rt(`EMU_STATUS_OFS, rd);
    chk_w(rd, 32'h02);
    chk_irq(1'b0, 1'b0, 1'b1);
    mem_rt(`EMU_CONTROL_OFS, rd);
    chk_w(rd, 32'h13);
    io_wt(`PORT_CMD, `A20_CMD, 1'b1);
    mem_rt(`EMU_CONTROL_OFS, rd);
    chk_w(rd, 32'h33);
    mem_rt(`EMU_STATUS_OFS, rd);
    chk_w(rd, 32'h0a);
    io_wt(`PORT_CMD, 8'h20, 1'b1);
    mem_rt(`EMU_CONTROL_OFS, rd);
    chk_w(rd, 32'h13);
    mem_rt(`EMU_INPUT_OFS, rd);
    chk_w(rd, 32'h20);
    mem_wt(`EMU_STATUS_OFS, 32'h0);
    chk_irq(1'b0, 1'b0, 1'b0);
    $display("test port writes done");
    // A20 sequence: matching data is swallowed, a mismatch counts as a normal write.
    io_wt(`PORT_CMD, `A20_CMD, 1'b1);
    mem_rt(`EMU_STATUS_OFS, rd);
    chk_w(rd, 32'h08);
    io_wt(`PORT_DATA, 8'h00, 1'b1);
    mem_rt(`EMU_STATUS_OFS, rd);
    chk_w(rd, 32'h00);
    io_wt(`PORT_DATA, 8'h02, 1'b1);
    mem_rt(`EMU_STATUS_OFS, rd);
    chk_w(rd, 32'h02);
    $display("test gate sequence done");
    mem_wt(`EMU_OUTPUT_OFS, 32'h77);
    mem_wt(`EMU_STATUS_OFS, 32'h01);
    mem_wt(`EMU_CONTROL_OFS, 32'h19);
    chk_irq(1'b1, 1'b0, 1'b0);
    io_rt(`PORT_CMD, bd);
    chk_b(bd, 8'h01);
    io_rt(`PORT_DATA, bd);
    chk_b(bd, 8'h77);
    chk_irq(1'b0, 1'b0, 1'b0);
    mem_rt(`EMU_STATUS_OFS, rd);
    chk_w(rd, 32'h0);
    mem_wt(`EMU_STATUS_OFS, 32'h21);
    chk_irq(1'b0, 1'b1, 1'b0);
    $display("test reply path done");
    mem_wt(`EMU_STATUS_OFS, 32'h0);
    mem_wt(`EMU_CONTROL_OFS, 32'h1d);
    chk_irq(1'b0, 1'b0, 1'b1);
    mem_rt(`EMU_CONTROL_OFS, rd);
    chk_w(rd, 32'h3f);
    mem_wt(`EMU_STATUS_OFS, 32'h01);
    chk_irq(1'b1, 1'b0, 1'b0);
    mem_wt(`EMU_STATUS_OFS, 32'h0);
    mem_wt(`EMU_CONTROL_OFS, 32'h10);
    io_wt(`PORT_DATA, 8'h99, 1'b0);
    mem_rt(`EMU_INPUT_OFS, rd);
    chk_w(rd, 32'h02);
    mem_rt(`EMU_STATUS_OFS, rd);
    chk_w(rd, 32'h0);
    $display("test pending and intercept off done");
    // Other ports are left alone even with interception on.
    mem_wt(`EMU_CONTROL_OFS, 32'h1d);
    io_wt(16'h0061, 8'h55, 1'b0);
    mem_rt(`EMU_INPUT_OFS, rd);
    chk_w(rd, 32'h02);
    mem_wt(`EMU_STATUS_OFS, 32'h01);
    chk_irq(1'b1, 1'b0, 1'b0);
    // A reset in mid-run must bring control, status and interrupts back.
    @(posedge mclk);
    reset <= 1'b1;
    cyc(4);
    reset <= 1'b0;
    mem_rt(`EMU_CONTROL_OFS, rd);
    chk_w(rd, 32'h10);
    mem_rt(`EMU_STATUS_OFS, rd);
    chk_w(rd, 32'h0);
    chk_irq(1'b0, 1'b0, 1'b0);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule : usb_legacy_keyboard_emulation_tb
